// ==== hw/rtcs_regs.svh ====
`ifndef RTCS_REGS_SVH
`define RTCS_REGS_SVH

// Command codes (bits 3..1 of the command byte); low bit selects register 1 or 2
`define RTCS_CMD_STATUS1     3'h0
`define RTCS_CMD_STATUS2     3'h1
`define RTCS_CMD_INT1        3'h4
`define RTCS_CMD_INT2        3'h5
`define RTCS_CMD_TRIM        3'h6
`define RTCS_CMD_FREE        3'h7

// Status register 2 fields
`define RTCS_SR2_ALARM1_BIT  5
`define RTCS_SR2_FREQ1_BIT   4
`define RTCS_SR2_ALARM2_BIT  1

// Clock trim control fields
`define RTCS_TRIM_SEL_BIT    0
`define RTCS_TRIM_CODE_MSB   7
`define RTCS_TRIM_CODE_LSB   1

// Reset values
`define RTCS_SR2_RESET       8'h00
`define RTCS_TRIM_RESET      8'h00
`define RTCS_INT1_RESET      8'h00

// Timing
`define RTCS_CLK_HZ          250000000
`define RTCS_OSC_HZ          32768
`define RTCS_HALF_CYCLES     (`RTCS_CLK_HZ / (2 * `RTCS_OSC_HZ))
`define RTCS_SEC_TICKS       17'h08000
`define RTCS_HALF_SEC        17'h04000
`define RTCS_INTERVAL_COARSE 6'h14
`define RTCS_INTERVAL_FINE   6'h3C

`endif

// ==== hw/rtcs_pkg.sv ====
package rtcs_pkg;

   typedef enum logic [3:0] {
      RTCS_IDLE  = 4'b0001,
      RTCS_CMD   = 4'b0010,
      RTCS_READ  = 4'b0100,
      RTCS_WRITE = 4'b1000
   } rtcs_state_t;

   typedef struct packed {
      logic cs;
      logic sck_n;
      logic sio;
   } rtcs_pins_t;

   typedef struct packed {
      logic       we;
      logic [4:0] addr;
      logic [7:0] wdata;
   } rtcs_mem_req_t;

endpackage : rtcs_pkg

// ==== hw/rtcs_regmem.sv ====
`timescale 1ns/1ns
module rtcs_regmem (
   // Clock
   input  wire logic                   clock_in,
   // Access
   input  wire rtcs_pkg::rtcs_mem_req_t req_in,
   output logic [7:0]                  rdata_out
);
   import rtcs_pkg::*;

   logic [7:0] mem [0:31];

   always_ff @(posedge clock_in) begin
      if (req_in.we) begin
         mem[req_in.addr] <= req_in.wdata;
      end
      rdata_out <= mem[req_in.addr];
   end

endmodule : rtcs_regmem

// ==== hw/rtcs_serial_trim.sv ====
// Behaviour
// R1 - Interval bit set: trim code steps about 1.017 ppm, +64.1 to -65.1 ppm.
// R2 - Interval bit clear: trim code steps about 3.052 ppm.
// R3 - One 1 Hz period in every 20 or 60 is lengthened or shortened.
// R4 - The 32.768 kHz output carries no trim adjustment.
// R5 - Host raises chip select, then changes data on serial clock falling edges.
// R6 - Each data bit is sampled on the following rising serial clock edge.
// R7 - Read/write bit 1 at the eighth rising edge enters the read state.
// R8 - In read state, register data is driven, changing on each falling edge.
// R9 - Read/write bit 0 at the eighth rising edge enters the write state.
// R10 - In write state, following bits are stored into the commanded register.
// R11 - Host supplies exactly as many clocks as the target register's bytes need; the testbench reads one-byte registers over two bytes.
// R12 - Under eight clocks in a transfer, nothing is read or written.
// R13 - Command select bit 0 picks status register 1, 1 picks register 2.
// R14 - Host sets status register 2 before touching interrupt register 1.
// R15 - Alarm mode makes interrupt register 1 three bytes, else one byte.
// R16 - User frequency mode uses interrupt register 1 to set the frequency.
// R17 - Second alarm enable set makes interrupt register 2 three bytes.
// R18 - Interrupt register 2 never drives a user frequency output.
// R19 - Trim code sits bit-reversed in bits 7..1, interval select in bit 0.
// R20 - One correction step every 20 s, or every 60 s with interval bit set.
// R21 - Data line released while chip select low or outside read output.
`timescale 1ns/1ns
`include "rtcs_regs.svh"
module rtcs_serial_trim #(
   parameter int HALF_CYCLES = `RTCS_HALF_CYCLES
) (
   // Clock and reset
   input  wire logic                clock_in,
   input  wire logic                srst_in,
   // Serial pins
   input  wire rtcs_pkg::rtcs_pins_t pins_in,
   output logic                     sio_out,
   output logic                     sio_oe_out,
   // Clock outputs
   output logic                     int_n_out,
   output logic                     clk32k_out
);
   import rtcs_pkg::*;

   localparam logic [11:0] DIV_LAST = 12'(HALF_CYCLES - 1);

   // Byte count of the register behind a command
   function automatic logic [1:0] byte_len(input logic [2:0] cmd, input logic [7:0] sr2);
      logic [1:0] len;
      len = 2'h1;
      if (cmd == `RTCS_CMD_INT1 && sr2[`RTCS_SR2_ALARM1_BIT]) begin
         len = 2'h3; // R15
      end
      if (cmd == `RTCS_CMD_INT2 && sr2[`RTCS_SR2_ALARM2_BIT]) begin
         len = 2'h3; // R17
      end
      return len;
   endfunction : byte_len

   // Last tick index of a corrected second
   function automatic logic [16:0] trim_last(input logic [7:0] trim);
      logic [6:0] v;
      v = 7'h00;
      for (int i = 0; i < 7; i++) begin
         v[i] = trim[`RTCS_TRIM_CODE_MSB - i]; // R19
      end
      // Two oscillator ticks per step at either interval
      return (`RTCS_SEC_TICKS - 17'h00001) - {{9{v[6]}}, v, 1'b0}; // R1 R2
   endfunction : trim_last

   // Pin synchronisers
   logic        cs_s1, cs_s2;
   logic        sck_s1, sck_s2, sck_d;
   logic        sio_s1, sio_s2;
   logic        sck_rise, sck_fall;

   // Serial state
   rtcs_state_t   state, next_state;
   logic [2:0]    bit_cnt, next_bit_cnt;
   logic [1:0]    byte_idx, next_byte_idx;
   logic [7:0]    shreg, next_shreg;
   logic [2:0]    cmd, next_cmd;
   logic          rd_load, next_rd_load;
   logic          next_sio, next_sio_oe;
   logic [7:0]    sr2, next_sr2;
   logic [7:0]    trim, next_trim;
   logic [7:0]    int1, next_int1;
   rtcs_mem_req_t req;
   logic [7:0]    rdata;
   logic [7:0]    in_byte;

   // Timebase state
   logic [11:0] div_cnt, next_div_cnt;
   logic        next_clk32k;
   logic [16:0] sub_cnt, next_sub_cnt;
   logic [5:0]  sec_cnt, next_sec_cnt;
   logic        next_int_n;
   logic        tick;
   logic [16:0] last;
   logic [5:0]  interval;
   logic        freq_mode;

   always_ff @(posedge clock_in) begin
      cs_s1  <= pins_in.cs;
      cs_s2  <= cs_s1;
      sck_s1 <= pins_in.sck_n;
      sck_s2 <= sck_s1;
      sck_d  <= sck_s2;
      sio_s1 <= pins_in.sio;
      sio_s2 <= sio_s1;
   end

   assign sck_rise = sck_s2 & ~sck_d;
   assign sck_fall = ~sck_s2 & sck_d;
   assign in_byte  = {shreg[6:0], sio_s2};

   rtcs_regmem rtcs_regmem_inst (
      .clock_in  (clock_in),
      .req_in    (req),
      .rdata_out (rdata)
   );

   always_comb begin
      next_state    = state;
      next_bit_cnt  = bit_cnt;
      next_byte_idx = byte_idx;
      next_shreg    = shreg;
      next_cmd      = cmd;
      next_rd_load  = 1'b0;
      next_sio      = sio_out;
      next_sio_oe   = sio_oe_out;
      next_sr2      = sr2;
      next_trim     = trim;
      next_int1     = int1;
      req           = '0;
      req.addr      = {cmd, byte_idx};
      if (!cs_s2) begin
         // Transfer cut short: partial bytes are simply dropped
         next_state    = RTCS_IDLE;
         next_bit_cnt  = 3'h0;
         next_byte_idx = 2'h0;
         next_sio_oe   = 1'b0; // R21
      end else begin
         case (state)
            RTCS_IDLE: begin
               next_state   = RTCS_CMD;
               next_bit_cnt = 3'h0;
            end
            RTCS_CMD: begin
               if (sck_rise) begin
                  next_shreg   = in_byte; // R6
                  next_bit_cnt = bit_cnt + 3'h1;
                  if (bit_cnt == 3'h7) begin // R12
                     next_cmd      = in_byte[3:1]; // R13
                     next_byte_idx = 2'h0;
                     if (in_byte[0]) begin
                        next_state   = RTCS_READ; // R7
                        req.addr     = {in_byte[3:1], 2'h0};
                        next_rd_load = 1'b1;
                     end else begin
                        next_state = RTCS_WRITE; // R9
                     end
                  end
               end
            end
            RTCS_READ: begin
               if (rd_load) begin
                  next_shreg = rdata;
               end else if (sck_fall) begin
                  next_sio     = shreg[7]; // R8
                  next_sio_oe  = 1'b1;
                  next_shreg   = {shreg[6:0], 1'b0};
                  next_bit_cnt = bit_cnt + 3'h1;
                  if (bit_cnt == 3'h7) begin
                     // Wraps to the first byte past the register's length
                     if (byte_idx + 2'h1 >= byte_len(cmd, sr2)) begin
                        next_byte_idx = 2'h0;
                     end else begin
                        next_byte_idx = byte_idx + 2'h1;
                     end
                     req.addr     = {cmd, next_byte_idx};
                     next_rd_load = 1'b1;
                  end
               end
            end
            RTCS_WRITE: begin
               next_sio_oe = 1'b0; // R21
               if (sck_rise) begin
                  next_shreg   = in_byte; // R6
                  next_bit_cnt = bit_cnt + 3'h1;
                  if (bit_cnt == 3'h7 && byte_idx < byte_len(cmd, sr2)) begin
                     req.we        = 1'b1; // R10
                     req.wdata     = in_byte;
                     next_byte_idx = byte_idx + 2'h1;
                     if (byte_idx == 2'h0) begin
                        case (cmd)
                           `RTCS_CMD_STATUS2: next_sr2 = in_byte;
                           `RTCS_CMD_TRIM:    next_trim = in_byte; // R19
                           `RTCS_CMD_INT1:    next_int1 = in_byte; // R16
                           default:           next_sr2 = sr2;
                        endcase
                     end
                  end
               end
            end
            default: begin
               next_state  = RTCS_IDLE;
               next_sio_oe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         state      <= RTCS_IDLE;
         bit_cnt    <= 3'h0;
         byte_idx   <= 2'h0;
         shreg      <= 8'h00;
         cmd        <= 3'h0;
         rd_load    <= 1'b0;
         sio_out    <= 1'b0;
         sio_oe_out <= 1'b0;
         sr2        <= `RTCS_SR2_RESET;
         trim       <= `RTCS_TRIM_RESET;
         int1       <= `RTCS_INT1_RESET;
      end else begin
         state      <= next_state;
         bit_cnt    <= next_bit_cnt;
         byte_idx   <= next_byte_idx;
         shreg      <= next_shreg;
         cmd        <= next_cmd;
         rd_load    <= next_rd_load;
         sio_out    <= next_sio;
         sio_oe_out <= next_sio_oe;
         sr2        <= next_sr2;
         trim       <= next_trim;
         int1       <= next_int1;
      end
   end

   // Trim acts on the divided count only, never on the oscillator itself
   always_comb begin
      tick         = (div_cnt == DIV_LAST) && !clk32k_out;
      next_div_cnt = (div_cnt == DIV_LAST) ? 12'h000 : div_cnt + 12'h001;
      next_clk32k  = (div_cnt == DIV_LAST) ? ~clk32k_out : clk32k_out; // R4
      interval     = trim[`RTCS_TRIM_SEL_BIT] ? `RTCS_INTERVAL_FINE
                                               : `RTCS_INTERVAL_COARSE; // R20
      last         = (sec_cnt == 6'h00) ? trim_last(trim)
                                        : `RTCS_SEC_TICKS - 17'h00001; // R3
      next_sub_cnt = sub_cnt;
      next_sec_cnt = sec_cnt;
      if (tick) begin
         if (sub_cnt >= last) begin
            next_sub_cnt = 17'h00000;
            next_sec_cnt = (sec_cnt >= interval - 6'h01) ? 6'h00 : sec_cnt + 6'h01; // R20
         end else begin
            next_sub_cnt = sub_cnt + 17'h00001;
         end
      end
      // Only register 1 can steer the frequency output
      freq_mode = sr2[`RTCS_SR2_FREQ1_BIT] && !sr2[`RTCS_SR2_ALARM1_BIT]; // R18
      if (freq_mode) begin
         next_int_n = ~|(int1 & sub_cnt[14:7]); // R16
      end else begin
         next_int_n = (sub_cnt >= `RTCS_HALF_SEC); // R3
      end
   end

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         div_cnt    <= 12'h000;
         clk32k_out <= 1'b0;
         sub_cnt    <= 17'h00000;
         sec_cnt    <= 6'h00;
         int_n_out  <= 1'b0;
      end else begin
         div_cnt    <= next_div_cnt;
         clk32k_out <= next_clk32k;
         sub_cnt    <= next_sub_cnt;
         sec_cnt    <= next_sec_cnt;
         int_n_out  <= next_int_n;
      end
   end

endmodule : rtcs_serial_trim

// ==== test/rtcs_serial_trim_monitor.sv ====
`timescale 1ns/1ns
module rtcs_serial_trim_monitor #(
   parameter int HALF_CYCLES = 2
) (
   // Clock and reset
   input wire logic                 clock_in,
   input wire logic                 srst_in,
   // Watched ports
   input wire rtcs_pkg::rtcs_pins_t pins_in,
   input wire logic                 sio_out,
   input wire logic                 sio_oe_out,
   input wire logic                 int_n_out,
   input wire logic                 clk32k_out
);
   import rtcs_pkg::*;
   logic [3:0]  n_rise;
   logic [7:0]  cmd;
   logic [15:0] half_cnt;
   logic        seen;
   logic        sck_q;
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (srst_in);
   // Pin-side counters run ahead of the device's synchronisers
   always_ff @(posedge clock_in) begin
      sck_q <= pins_in.sck_n;
      if (srst_in || !pins_in.cs) begin
         n_rise <= 4'h0;
      end else if (pins_in.sck_n && !sck_q && n_rise < 4'hF) begin
         n_rise <= n_rise + 4'h1;
         if (n_rise < 4'h8) cmd <= {cmd[6:0], pins_in.sio};
      end
      if (srst_in) begin
         half_cnt <= 16'h0;
         seen     <= 1'b0;
      end else if ($changed(clk32k_out)) begin
         half_cnt <= 16'h1;
         seen     <= 1'b1;
      end else begin
         half_cnt <= half_cnt + 16'h1;
      end
   end
   a_oe_idle_cs: assert property ((!pins_in.cs) [*6] |-> !sio_oe_out)
      else $error("data line driven with chip select low");
   a_oe_fall_cs: assert property ($fell(sio_oe_out) |-> !$past(pins_in.cs, 2))
      else $error("data line released inside a frame");
   a_oe_on_fall: assert property ($rose(sio_oe_out)
      |-> !pins_in.sck_n && !$past(pins_in.sck_n, 3))
      else $error("read output started off a falling edge");
   a_data_on_fall: assert property ($changed(sio_out) && sio_oe_out && $past(sio_oe_out)
      |-> !pins_in.sck_n && !$past(pins_in.sck_n, 3))
      else $error("read data changed off a falling edge");
   a_read_cmd_bit: assert property ($rose(sio_oe_out) |-> cmd[0])
      else $error("read output after a write command");
   a_clock_wait: assert property ($rose(sio_oe_out) |-> n_rise >= 4'h8)
      else $error("read output before eight clocks");
   a_clk32k_half: assert property ($changed(clk32k_out) && seen
      |-> half_cnt == 16'(HALF_CYCLES))
      else $error("32 kHz output half period wrong");
   a_reset_quiet: assert property ($fell(srst_in) |-> !sio_oe_out && !clk32k_out && !int_n_out)
      else $error("outputs active at reset release");
endmodule : rtcs_serial_trim_monitor
bind rtcs_serial_trim rtcs_serial_trim_monitor #(.HALF_CYCLES(HALF_CYCLES))
   rtcs_serial_trim_monitor_inst (
   .clock_in(clock_in), .srst_in(srst_in), .pins_in(pins_in), .sio_out(sio_out),
   .sio_oe_out(sio_oe_out), .int_n_out(int_n_out), .clk32k_out(clk32k_out));

// ==== test/rtcs_host.sv ====
`timescale 1ns/1ns
module rtcs_host (
   // Clock
   input  wire logic           clock_in,
   // Device side
   input  wire logic           sio_out,
   input  wire logic           sio_oe_out,
   output rtcs_pkg::rtcs_pins_t pins_out
);
   import rtcs_pkg::*;
   logic cs    = 1'b0;
   logic sck_n = 1'b1;
   logic drv   = 1'b0;
   // Device wins the wire while it drives; no pull, so host bits keep moving
   assign pins_out = {cs, sck_n, sio_oe_out ? sio_out : drv};
   // Serial clock stands high outside frames
   task automatic frame(input logic [31:0] bits, input int n, output logic [31:0] got);
      got = '0;
      @(negedge clock_in);
      cs = 1'b1;
      repeat (4) @(negedge clock_in);
      for (int i = 0; i < n; i++) begin
         sck_n = 1'b0;
         drv   = bits[31 - i];
         repeat (10) @(negedge clock_in);
         sck_n = 1'b1;
         got   = {got[30:0], pins_out.sio};
         repeat (10) @(negedge clock_in);
      end
      cs  = 1'b0;
      drv = ~drv;
      repeat (8) @(negedge clock_in);
   endtask : frame
endmodule : rtcs_host

// ==== test/test_rtcs_serial_trim.sv ====
`timescale 1ns/1ns
module test_rtcs_serial_trim;
   import rtcs_pkg::*;
   // Shortest divider keeps a whole corrected second inside the run budget
   localparam int HALF = 1;
   logic        clock_in = 1'b0;
   logic        srst_in  = 1'b1;
   rtcs_pins_t  pins;
   logic        sio_out;
   logic        sio_oe_out;
   logic        int_n_out;
   logic        clk32k_out;
   int          n_errors    = 0;
   int          comparisons = 0;
   int          cycles      = 0;
   int          t0;
   int          seed        = 32'he44316ce;
   logic [31:0] got;
   logic [7:0]  v;
   logic [23:0] d;
   logic [2:0]  codes [4]   = '{3'h6, 3'h2, 3'h3, 3'h7};
   always #2 clock_in = ~clock_in;
   rtcs_serial_trim #(.HALF_CYCLES(HALF)) rtcs_serial_trim_inst (
      .clock_in(clock_in), .srst_in(srst_in), .pins_in(pins), .sio_out(sio_out),
      .sio_oe_out(sio_oe_out), .int_n_out(int_n_out), .clk32k_out(clk32k_out));
   rtcs_host rtcs_host_inst (.clock_in(clock_in), .sio_out(sio_out),
      .sio_oe_out(sio_oe_out), .pins_out(pins));
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic complete_run;
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : complete_run
   // One-byte register read twice wraps onto itself
   function automatic logic [23:0] wrap(input logic [7:0] b);
      return {8'h0, b, b};
   endfunction : wrap
   // Ticks in a corrected second: two per step, code bit-reversed in bits 7..1
   function automatic int trim_ticks(input logic [7:0] t);
      logic signed [6:0] c;
      for (int i = 0; i < 7; i++) c[i] = t[7 - i];
      return 32768 - 2 * int'(c);
   endfunction : trim_ticks
   // Write data rides left-aligned; reads send a moving pattern
   task automatic xfer(input logic [2:0] c, input logic rd, input int len, input logic [23:0] w);
      rtcs_host_inst.frame({4'h0, c, rd, rd ? 24'hAAAAAA : w}, 8 + 8 * len, got);
   endtask : xfer
   task automatic wait_rise;
      while (int_n_out !== 1'b0) @(negedge clock_in);
      while (int_n_out !== 1'b1) @(negedge clock_in);
   endtask : wait_rise
   always @(posedge clock_in) begin
      cycles <= cycles + 1;
      if (cycles == 100000) begin
         n_errors++;
         complete_run();
      end
   end
   initial begin
      repeat (20) @(negedge clock_in);
      srst_in = 1'b0;
      t0 = cycles;
      repeat (4) @(negedge clock_in);
      xfer(3'h1, 1'b0, 1, 24'h0);
      foreach (codes[i]) begin
         v = (i == 0) ? 8'hFC : 8'($random(seed));
         xfer(codes[i], 1'b0, 1, {v, 16'h0});
         xfer(codes[i], 1'b1, 2, 24'h0);
         check({8'h0, got[15:0]}, wrap(v));
      end
      xfer(3'h6, 1'b0, 1, 24'h030000);
      rtcs_host_inst.frame(32'h0E000000, 7, got);
      xfer(3'h7, 1'b1, 1, 24'h0);
      check({16'h0, got[7:0]}, {16'h0, v});
      xfer(3'h1, 1'b0, 1, 24'h220000);
      xfer(3'h1, 1'b1, 1, 24'h0);
      check({16'h0, got[7:0]}, 24'h000022);
      for (int c = 5; c > 3; c--) begin
         d = 24'($random(seed));
         xfer(3'(c), 1'b0, 3, d);
         xfer(3'(c), 1'b1, 3, 24'h0);
         check(got[23:0], d);
      end
      xfer(3'h1, 1'b0, 1, 24'h0);
      xfer(3'h4, 1'b1, 2, 24'h0);
      check({8'h0, got[15:0]}, wrap(d[23:16]));
      wait_rise();
      check(24'((cycles - t0 >= 32768 * HALF) && (cycles - t0 <= 32768 * HALF + 10)),
         24'h1);
      while (int_n_out !== 1'b0) @(negedge clock_in);
      check(24'(cycles - t0), 24'(trim_ticks(8'h03) * 2 * HALF));
      xfer(3'h1, 1'b0, 1, 24'h100000);
      xfer(3'h4, 1'b0, 1, 24'h010000);
      wait_rise();
      t0 = cycles;
      wait_rise();
      check(24'(cycles - t0), 24'(256 * 2 * HALF));
      xfer(3'h4, 1'b0, 1, 24'h0);
      xfer(3'h5, 1'b0, 1, 24'hFF0000);
      v = 8'h0;
      repeat (2048) begin
         @(negedge clock_in);
         if (int_n_out !== 1'b1) v = 8'h1;
      end
      check({16'h0, v}, 24'h0);
      complete_run();
   end
endmodule : test_rtcs_serial_trim
